/* design/iapl_pkg.sv */
// Shared constants for the interrupt pin logic block
package iapl_pkg;
  localparam int unsigned NUM_IRQ      = 16;
  localparam int unsigned KBD_IRQ      = 1;
  localparam int unsigned RTC_IRQ      = 8;
  localparam int unsigned DEFAULT_IRQ  = 7;
  localparam int unsigned SYNC_STAGES  = 3;
  localparam int unsigned ADDR_W       = 32;
  localparam int unsigned FLUSH_TMO_CYC = 16;
  // Inputs that may be set to level sensing: 3:7, 9:11, 14:15
  localparam logic [15:0] PROG_SENSE_MASK = 16'hcef8;
  // Inputs physically wired as requests (0, 2, 13 are internal)
  localparam logic [15:0] PIN_IRQ_MASK    = 16'hdffa;
  localparam logic [15:0] SENSE_RESET     = 16'h0000;
  localparam logic [3:0]  VEC_NONE        = 4'h0;
  typedef enum logic [1:0] {FL_IDLE, FL_FLUSH, FL_ACK} iapl_flush_t;
endpackage : iapl_pkg

/* design/iapl_sync.sv */
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module iapl_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic s1Reg;
  logic s2Reg;
  logic s3Reg;
  // RULE17 three-stage sync
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1Reg <= RESET_VAL;
      s2Reg <= RESET_VAL;
      s3Reg <= RESET_VAL;
    end else begin
      s1Reg <= asyncIn;
      s2Reg <= s1Reg;
      s3Reg <= s2Reg;
    end
  end
  // Change counts once stages two and three agree
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      syncOut <= RESET_VAL;
    end else if (s2Reg == s3Reg) begin
      syncOut <= s3Reg;
    end
  end
endmodule : iapl_sync
`default_nettype wire

/* design/iapl_top.sv */
// Interrupt request front end with APIC flush and select pins
// Function
// RULE1: After buffer flush completes, drive flush acknowledge low.
// RULE2: Flush acknowledge is generated on the PCI clock.
// RULE3: External APIC asserts flush request before sending interrupt message.
// RULE4: On flush request, flush DMA buffers toward PCI before acknowledging.
// RULE5: External APIC waits for acknowledge before sending its message.
// RULE6: Chip select only when enabled and PCI cycle hits APIC range.
// RULE7: Timer output pin follows internal system timer request.
// RULE8: Keyboard input is rising-edge latched only, never level.
// RULE9: Request dropped before acknowledge reports default level seven.
// RULE10: Sources hold request until the acknowledge has occurred.
// RULE11: Inputs 3-7, 9-11, 14-15 edge or high level, edge default.
// RULE12: Real-time-clock input is fixed active-low edge triggered.
// RULE13: RTC pin is general input on internal clock, output with APIC.
// RULE14: Interrupt-9 output carries system-control and SMBus interrupts.
// RULE15: Without APIC the pins serve as general outputs and inputs.
// RULE16: Reset holds acknowledge, select, irq9 high and timer low.
// RULE17: Asynchronous requests pass a synchroniser before sensing.
`timescale 1ns/1ps
`default_nettype none
module iapl_top (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // APIC present and enabled
  input  wire logic        apicEnable,
  input  wire logic        apicSelectEnable,
  input  wire logic        useInternalRtc,
  // Flush handshake
  input  wire logic        apic_flush_req_n,
  output logic             apic_flush_ack_n,
  output logic             flushStart,
  input  wire logic        flushDone,
  // Chip select decode
  input  wire logic        pciCycleValid,
  input  wire logic [31:0] pciAddr,
  input  wire logic [31:0] apicBase,
  input  wire logic [31:0] apicLimit,
  output logic             apic_select_n,
  // Timer and irq9
  input  wire logic        systemTimerIrq,
  output logic             timer_irq_out,
  input  wire logic        system_control_interrupt,
  input  wire logic        smbusIrq,
  output logic             acpi_smbus_irq_out_n,
  // Request pins
  input  wire logic [15:0] irqIn,
  input  wire logic        rtc_irq_in_n,
  output logic             rtcPinOut,
  output logic             rtcPinOe,
  input  wire logic        rtcFromInternal,
  input  wire logic [15:0] levelSenseSel,
  // Acknowledge cycle
  input  wire logic        intAckCycle,
  output logic [3:0]       intAckVector,
  output logic             intAckValid,
  output logic             cpu_interrupt_out,
  // General purpose alternate use
  input  wire logic        gp_out_ack_alt,
  input  wire logic        gp_out_select_alt,
  input  wire logic        gp_out_timer_alt,
  input  wire logic        gp_out_irq9_alt,
  output logic             gp_in_req_alt,
  output logic             gp_in_rtc_alt
);
  logic [15:0]         irqSync;
  logic [15:0]         irqPrev_reg;
  logic [15:0]         pending_reg;
  logic [15:0]         senseLevel_reg;
  logic [15:0]         rawReq;
  logic [15:0]         active;
  logic                rtcSync;
  logic [3:0]          bestVec;
  logic                bestHit;
  iapl_pkg::iapl_flush_t flState_reg;
  logic                reqSampled;
  logic                selHit;
  logic                ackLow;
  logic [15:0]         ackClear;

  // Request pins synchronised, one instance per wired line; internal lines 0, 2, 13 and RTC line 8 tied low
  genvar g;
  generate
    for (g = 0; g < iapl_pkg::NUM_IRQ; g++) begin : gSync
      if (iapl_pkg::PIN_IRQ_MASK[g] && g != iapl_pkg::RTC_IRQ) begin : gPin
        iapl_sync #(.RESET_VAL(1'b0)) uSync (
          .ref_clk (ref_clk),
          .rst     (rst),
          .asyncIn (irqIn[g]),
          .syncOut (irqSync[g])
        );
      end else begin : gNone
        assign irqSync[g] = 1'b0;
      end
    end
  endgenerate

  iapl_sync #(.RESET_VAL(1'b1)) uRtcSync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .asyncIn (rtc_irq_in_n),
    .syncOut (rtcSync)
  );

  // Flush request is synchronous to the PCI clock already
  assign reqSampled = ~apic_flush_req_n;

  // Acknowledge low once flushed, held while the request stays low
  assign ackLow = (flState_reg == iapl_pkg::FL_FLUSH && flushDone)
                  || (flState_reg == iapl_pkg::FL_ACK && reqSampled);

  // Chip-select range hit, inclusive at both ends
  assign selHit = apicSelectEnable && pciCycleValid
                  && pciAddr >= apicBase && pciAddr <= apicLimit;

  // RULE11 sense select, edge default, fixed lines forced edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      senseLevel_reg <= iapl_pkg::SENSE_RESET;
    end else begin
      senseLevel_reg <= levelSenseSel & iapl_pkg::PROG_SENSE_MASK;
    end
  end

  // RULE12 RTC line taken active low; unusable when pin is output
  always_comb begin
    rawReq = irqSync;
    rawReq[iapl_pkg::RTC_IRQ] = ~rtcSync & ~apicEnable & ~useInternalRtc;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqPrev_reg <= 16'h0000;
    end else begin
      irqPrev_reg <= rawReq;
    end
  end

  // RULE8 keyboard never level; edges latched into pending
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pending_reg <= 16'h0000;
    end else begin
      // A new edge wins over a clear in the same cycle
      for (int i = 0; i < iapl_pkg::NUM_IRQ; i++) begin
        if (senseLevel_reg[i]) begin
          pending_reg[i] <= rawReq[i];
        end else if (rawReq[i] && !irqPrev_reg[i]) begin
          pending_reg[i] <= 1'b1;
        end else if (ackClear[i]) begin
          pending_reg[i] <= 1'b0;
        end
      end
    end
  end

  // RULE9 edge request must still be held to count
  assign active = pending_reg & (rawReq | senseLevel_reg);

  // One-hot clear of the line granted by an acknowledge
  always_comb begin
    ackClear = 16'h0000;
    if (intAckCycle && bestHit) begin
      ackClear[bestVec] = 1'b1;
    end
  end

  always_comb begin
    bestVec = iapl_pkg::VEC_NONE;
    bestHit = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (active[i]) begin
        bestVec = 4'(i);
        bestHit = 1'b1;
      end
    end
  end

  // RULE9 default level seven when request vanished
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      intAckVector <= iapl_pkg::VEC_NONE;
      intAckValid  <= 1'b0;
    end else begin
      intAckValid <= intAckCycle;
      if (intAckCycle) begin
        intAckVector <= bestHit ? bestVec : 4'(iapl_pkg::DEFAULT_IRQ);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpu_interrupt_out <= 1'b0;
    end else begin
      cpu_interrupt_out <= |active;
    end
  end

  // RULE4 flush first, then RULE1 acknowledge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flState_reg <= iapl_pkg::FL_IDLE;
    end else if (!apicEnable) begin
      // Handshake dropped when the APIC is switched off
      flState_reg <= iapl_pkg::FL_IDLE;
    end else begin
      unique case (flState_reg)
        iapl_pkg::FL_IDLE: begin
          if (apicEnable && reqSampled) begin
            flState_reg <= iapl_pkg::FL_FLUSH;
          end
        end
        iapl_pkg::FL_FLUSH: begin
          if (flushDone) begin
            flState_reg <= iapl_pkg::FL_ACK;
          end
        end
        iapl_pkg::FL_ACK: begin
          if (!reqSampled) begin
            flState_reg <= iapl_pkg::FL_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flushStart <= 1'b0;
    end else begin
      flushStart <= (flState_reg == iapl_pkg::FL_IDLE) && apicEnable
                    && reqSampled;
    end
  end

  // RULE2 acknowledge registered on the PCI clock
  // RULE15 general output when APIC unused
  // RULE16 reset value high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      apic_flush_ack_n <= 1'b1;
    end else if (!apicEnable) begin
      apic_flush_ack_n <= gp_out_ack_alt;
    end else begin
      apic_flush_ack_n <= !ackLow;
    end
  end

  // RULE6 select on enabled range hit
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      apic_select_n <= 1'b1;
    end else if (!apicEnable) begin
      apic_select_n <= gp_out_select_alt;
    end else begin
      apic_select_n <= !selHit;
    end
  end

  // RULE7 timer pin follows internal timer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer_irq_out <= 1'b0;
    end else begin
      timer_irq_out <= apicEnable ? systemTimerIrq : gp_out_timer_alt;
    end
  end

  // RULE14 irq9 carries control and SMBus interrupts
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acpi_smbus_irq_out_n <= 1'b1;
    end else if (apicEnable) begin
      acpi_smbus_irq_out_n <= !(system_control_interrupt || smbusIrq);
    end else begin
      acpi_smbus_irq_out_n <= gp_out_irq9_alt;
    end
  end

  // RULE13 RTC pin direction and general input use
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rtcPinOe      <= 1'b0;
      rtcPinOut     <= 1'b1;
      gp_in_rtc_alt <= 1'b1;
    end else begin
      rtcPinOe      <= apicEnable;
      rtcPinOut     <= ~rtcFromInternal;
      gp_in_rtc_alt <= rtcSync;
    end
  end

  // RULE15 request pin as general input
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gp_in_req_alt <= 1'b1;
    end else begin
      gp_in_req_alt <= apic_flush_req_n;
    end
  end
endmodule : iapl_top
`default_nettype wire

/* testbench/iapl_apic_model.sv */
// Behavioural external APIC for the flush handshake
`timescale 1ns/1ps
`default_nettype none
module iapl_apic_model (
  input  wire logic ref_clk,
  input  wire logic apic_flush_ack_n,
  output var logic  apic_flush_req_n
);
  initial apic_flush_req_n = 1'b1;
  task automatic send(input int hold);
    int n;
    n = 0;
    apic_flush_req_n = 1'b0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (apic_flush_ack_n !== 1'b0 && n < 40);
    repeat (hold) @(posedge ref_clk);
    #2;
    apic_flush_req_n = 1'b1;
  endtask : send
endmodule : iapl_apic_model
`default_nettype wire

/* testbench/iapl_top_assertions.sv */
// Port assertions for the interrupt pin logic
`timescale 1ns/1ps
`default_nettype none
module iapl_top_assertions (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        apicEnable,
  input wire logic        apicSelectEnable,
  input wire logic        apic_flush_req_n,
  input wire logic        apic_flush_ack_n,
  input wire logic        flushStart,
  input wire logic        flushDone,
  input wire logic        pciCycleValid,
  input wire logic [31:0] pciAddr,
  input wire logic [31:0] apicBase,
  input wire logic [31:0] apicLimit,
  input wire logic        apic_select_n,
  input wire logic        systemTimerIrq,
  input wire logic        timer_irq_out,
  input wire logic        system_control_interrupt,
  input wire logic        smbusIrq,
  input wire logic        acpi_smbus_irq_out_n,
  input wire logic        rtcPinOe,
  input wire logic        gp_out_ack_alt
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic onPrev_reg, offPrev_reg, on2, off2, hit;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      onPrev_reg  <= 1'b0;
      offPrev_reg <= 1'b0;
    end else begin
      onPrev_reg  <= apicEnable;
      offPrev_reg <= !apicEnable;
    end
  end
  assign on2 = apicEnable && onPrev_reg;
  assign off2 = !apicEnable && offPrev_reg;
  assign hit = apicSelectEnable && pciCycleValid
    && pciAddr >= apicBase && pciAddr <= apicLimit;
  AST_ACK_AFTER_DONE:
    assert property (on2 && $fell(apic_flush_ack_n) |-> $past(flushDone))
    else $error("ack fell without flush done");
  AST_ACK_RELEASE:
    assert property (on2 && apic_flush_req_n && !apic_flush_ack_n
      |=> apic_flush_ack_n || !apicEnable)
    else $error("ack held after request release");
  AST_START_ON_REQ:
    assert property ($rose(flushStart)
      |-> !$past(apic_flush_req_n) && onPrev_reg)
    else $error("flush start without request");
  AST_START_NO_ACK:
    assert property (on2 && flushStart |-> apic_flush_ack_n ##1 !flushStart)
    else $error("ack during flush start");
  AST_SEL_HIT:
    assert property (apicEnable && hit ##1 apicEnable |-> !apic_select_n)
    else $error("select missing on hit");
  AST_SEL_MISS:
    assert property (apicEnable && !hit ##1 apicEnable |-> apic_select_n)
    else $error("select without hit");
  AST_TIMER:
    assert property (on2 |-> timer_irq_out == $past(systemTimerIrq))
    else $error("timer pin wrong");
  AST_IRQ9:
    assert property (on2 |-> acpi_smbus_irq_out_n
      != ($past(system_control_interrupt) || $past(smbusIrq)))
    else $error("irq9 pin wrong");
  AST_GP_ACK:
    assert property (off2 && $stable(gp_out_ack_alt)
      |-> apic_flush_ack_n == gp_out_ack_alt)
    else $error("ack pin not general output");
  AST_RTC_OE:
    assert property (onPrev_reg || offPrev_reg |-> rtcPinOe == onPrev_reg)
    else $error("rtc pin enable wrong");
  cover property ($fell(apic_flush_ack_n));
  cover property (flushStart);
  cover property (!apic_select_n);
endmodule : iapl_top_assertions
`default_nettype wire

/* testbench/iapl_top_tb.sv */
// Self-checking bench for the interrupt pin logic
`timescale 1ns/1ps
`default_nettype none
module iapl_top_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic apicEnable, apicSelectEnable, useInternalRtc, flushDone, pciCycleValid;
  logic systemTimerIrq, system_control_interrupt, smbusIrq, rtc_irq_in_n;
  logic rtcFromInternal, intAckCycle, gp_out_ack_alt, gp_out_select_alt;
  logic gp_out_timer_alt, gp_out_irq9_alt, apic_flush_req_n, apic_flush_ack_n;
  logic flushStart, apic_select_n, timer_irq_out, acpi_smbus_irq_out_n;
  logic rtcPinOe, intAckValid, rtcPinOut, cpu_interrupt_out;
  logic gp_in_req_alt, gp_in_rtc_alt;
  logic [5:0] expPins;
  logic [3:0] intAckVector;
  logic [31:0] pciAddr, apicBase, apicLimit;
  logic [15:0] irqIn, levelSenseSel;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  always #20 ref_clk = ~ref_clk;
  iapl_top u_iapl_top (.ref_clk, .rst, .apicEnable, .apicSelectEnable,
    .useInternalRtc, .apic_flush_req_n, .apic_flush_ack_n, .flushStart,
    .flushDone, .pciCycleValid, .pciAddr, .apicBase, .apicLimit,
    .apic_select_n, .systemTimerIrq, .timer_irq_out, .system_control_interrupt,
    .smbusIrq, .acpi_smbus_irq_out_n, .irqIn, .rtc_irq_in_n, .rtcPinOut,
    .rtcPinOe, .rtcFromInternal, .levelSenseSel, .intAckCycle, .intAckVector,
    .intAckValid, .cpu_interrupt_out, .gp_out_ack_alt, .gp_out_select_alt,
    .gp_out_timer_alt, .gp_out_irq9_alt, .gp_in_req_alt, .gp_in_rtc_alt);
  iapl_apic_model u_iapl_apic_model (.ref_clk, .apic_flush_ack_n,
    .apic_flush_req_n);
  task automatic end_sim;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic chkVec(input logic [3:0] g, input logic [3:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chkVec
  task automatic chkBit(input logic g, input logic e);
    chkVec({3'h0, g}, {3'h0, e});
  endtask : chkBit
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : tick
  function automatic logic [3:0] lowest(input logic [15:0] m);
    lowest = 4'h7;
    for (int i = 15; i >= 0; i--)
      if (m[i]) lowest = i[3:0];
  endfunction : lowest
  // Expected pins one cycle after the current inputs, handshake idle
  function automatic logic [5:0] pinExp();
    logic hit;
    hit = apicSelectEnable && pciCycleValid && pciAddr >= apicBase
      && pciAddr <= apicLimit;
    pinExp[0] = apicEnable ? !hit : gp_out_select_alt;
    pinExp[1] = apicEnable ? systemTimerIrq : gp_out_timer_alt;
    pinExp[2] = apicEnable ? !(system_control_interrupt || smbusIrq)
      : gp_out_irq9_alt;
    pinExp[3] = apicEnable | gp_out_ack_alt;
    pinExp[4] = !rtcFromInternal;
    pinExp[5] = apicEnable;
  endfunction : pinExp
  task automatic iack(input logic [15:0] act);
    intAckCycle = 1'b1;
    tick(1);
    intAckCycle = 1'b0;
    chkBit(intAckValid, 1'b1);
    chkVec(intAckVector, lowest(act));
    tick(1);
    chkBit(intAckValid, 1'b0);
  endtask : iack
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    {apicSelectEnable, useInternalRtc, flushDone, pciCycleValid} = 4'h0;
    {systemTimerIrq, system_control_interrupt, smbusIrq} = 3'h0;
    {rtcFromInternal, intAckCycle, irqIn, levelSenseSel, pciAddr} = '0;
    {apicEnable, rtc_irq_in_n, gp_out_ack_alt, gp_out_select_alt} = 4'hf;
    {gp_out_timer_alt, gp_out_irq9_alt} = 2'h3;
    apicBase = 32'hfec00000;
    apicLimit = 32'hfec003ff;
    void'($urandom(49068));
    tick(6);
    chkVec({apic_flush_ack_n, apic_select_n, acpi_smbus_irq_out_n,
      timer_irq_out}, 4'he);
    tick(6);
    rst = 1'b0;
    for (int i = 0; i < 400; i++) begin
      if (i % 50 == 0) apicEnable = 1'($urandom);
      {apicSelectEnable, pciCycleValid, systemTimerIrq, smbusIrq,
        system_control_interrupt, gp_out_ack_alt, gp_out_select_alt,
        gp_out_timer_alt, gp_out_irq9_alt, rtcFromInternal} = 10'($urandom);
      pciAddr = apicBase + 32'($urandom_range(1032)) - 32'h4;
      expPins = pinExp();
      tick(1);
      chkBit(apic_select_n, expPins[0]);
      chkBit(timer_irq_out, expPins[1]);
      chkBit(acpi_smbus_irq_out_n, expPins[2]);
      chkBit(apic_flush_ack_n, expPins[3]);
      chkVec({2'h0, rtcPinOe, rtcPinOut}, {2'h0, expPins[5:4]});
    end
    {apicEnable, apicSelectEnable, pciCycleValid, gp_out_ack_alt} = 4'hf;
    for (int k = 0; k < 4; k++) begin
      pciAddr = k[1] ? apicLimit + 32'(k[0]) : apicBase - 32'(!k[0]);
      tick(1);
      chkBit(apic_select_n, !(k[0] ^ k[1]));
    end
    for (int h = 0; h < 2; h++) begin
      fork
        u_iapl_apic_model.send(h * 3);
        begin
          for (int n = 0; n < 9 && flushStart !== 1'b1; n++) tick(1);
          chkBit(flushStart, 1'b1);
          chkBit(apic_flush_ack_n, 1'b1);
          repeat (h * 4) tick(1);
          flushDone = 1'b1;
          tick(1);
          flushDone = 1'b0;
          tick(1);
          chkBit(apic_flush_ack_n, 1'b0);
        end
      join
      tick(2);
      chkBit(apic_flush_ack_n, 1'b1);
    end
    {apicEnable, useInternalRtc} = 2'h0;
    fork
      u_iapl_apic_model.send(0);
      repeat (12) begin
        tick(1);
        chkBit(flushStart, 1'b0);
        chkBit(gp_in_req_alt, 1'b0);
      end
    join
    levelSenseSel = 16'hffff;
    irqIn[1] = 1'b1;
    tick(8);
    chkBit(cpu_interrupt_out, 1'b1);
    iack(16'h0002);
    iack(16'h0000);
    {irqIn[1], irqIn[5]} = 2'h1;
    tick(8);
    iack(16'h0020);
    iack(16'h0020);
    {irqIn[5], irqIn[3], irqIn[14], levelSenseSel} = {3'h3, 16'h0};
    tick(8);
    iack(16'h4008);
    iack(16'h4000);
    {irqIn[3], irqIn[14], irqIn[4]} = 3'h1;
    tick(8);
    irqIn[4] = 1'b0;
    tick(8);
    chkBit(cpu_interrupt_out, 1'b0);
    iack(16'h0000);
    rtc_irq_in_n = 1'b0;
    tick(8);
    chkBit(gp_in_rtc_alt, 1'b0);
    iack(16'h0100);
    end_sim();
  end
endmodule : iapl_top_tb
bind iapl_top iapl_top_assertions u_iapl_top_assertions (.ref_clk, .rst,
  .apicEnable, .apicSelectEnable, .apic_flush_req_n, .apic_flush_ack_n,
  .flushStart, .flushDone, .pciCycleValid, .pciAddr, .apicBase, .apicLimit,
  .apic_select_n, .systemTimerIrq, .timer_irq_out, .system_control_interrupt,
  .smbusIrq, .acpi_smbus_irq_out_n, .rtcPinOe, .gp_out_ack_alt);
`default_nettype wire
